// >>> inc/adsq_consts.svh
`ifndef ADSQ_CONSTS_SVH
`define ADSQ_CONSTS_SVH

// ========================================
// Register indices on the plain port
`define ADSQ_ADDR_W 3
`define ADSQ_IDX_CTRL_A 3'h0
`define ADSQ_IDX_CTRL_B 3'h1
`define ADSQ_IDX_RES_LOW 3'h2
`define ADSQ_IDX_RES_HIGH 3'h3
`define ADSQ_IDX_IRQ_STAT 3'h4
`define ADSQ_IDX_IRQ_MASK 3'h5

// ========================================
// Reset values
`define ADSQ_CTRL_RST 8'h00
`define ADSQ_RES_RST 8'h00
`define ADSQ_IRQ_RST 8'h00

// ========================================
// Control A fields
`define ADSQ_A_START 7
`define ADSQ_A_BUSY 6
`define ADSQ_A_EN 5
`define ADSQ_A_JUST 4
`define ADSQ_A_CH_HI 3
`define ADSQ_A_CH_LO 0
`define ADSQ_A_WMASK 8'hbf

// ========================================
// Control B fields
`define ADSQ_B_SRC_HI 7
`define ADSQ_B_SRC_LO 5
`define ADSQ_B_REF_HI 4
`define ADSQ_B_REF_LO 3
`define ADSQ_B_DIV_HI 2
`define ADSQ_B_DIV_LO 0

// ========================================
// Field encodings
`define ADSQ_SRC_BANDGAP 3'h1
`define ADSQ_SRC_GND_LO 3'h2
`define ADSQ_SRC_GND_HI 3'h4
`define ADSQ_REF_SUPPLY 2'h1
`define ADSQ_IRQ_DONE 0
`define ADSQ_IRQ_WMASK 8'h01

// ========================================
// Converter geometry
`define ADSQ_NUM_CH 8
`define ADSQ_DIV_W 7
`define ADSQ_CONV_CLKS 16

`endif

// >>> inc/adsq_conv_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adsq_conv_if;
	logic start;
	logic abort;
	logic [2:0] div_sel;
	logic tick;
	logic done;
	logic active;
	modport ctrl(output start, abort, div_sel, input tick, done, active);
	modport core(input start, abort, div_sel, output tick, done, active);
endinterface
`default_nettype wire

// >>> inc/adsq_pkg.sv
package adsq_pkg;
	typedef enum logic [0:0] {ST_IDLE, ST_CONV} adsq_state_e;
	typedef enum logic [1:0] {SRC_EXT, SRC_BANDGAP, SRC_GROUND} adsq_src_e;
	typedef logic [11:0] adsq_data_t;
	typedef logic [7:0] adsq_byte_t;
endpackage

// >>> rtl/adsq_conv_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "adsq_consts.svh"
module adsq_conv_timer import adsq_pkg::*; #(
	parameter int CONV_CLKS = `ADSQ_CONV_CLKS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link to the register side
	adsq_conv_if.core cif
);
	localparam int CNT_W = 8;

	if (CONV_CLKS < 1 || CONV_CLKS > 255) begin : g_bad_len
		$error("CONV_CLKS must lie in 1..255");
	end

	// ========================================
	// Conversion clock divider
	function automatic logic [`ADSQ_DIV_W-1:0] div_mask(input logic [2:0] sel);
		logic [`ADSQ_DIV_W:0] full;
		full = (8'h01 << sel) - 8'h01;
		return full[`ADSQ_DIV_W-1:0];
	endfunction

	logic [`ADSQ_DIV_W-1:0] div_reg;
	logic [`ADSQ_DIV_W-1:0] mask;
	logic tick_now;
	logic tick_reg;

	assign mask = div_mask(cif.div_sel);
	assign tick_now = (div_reg & mask) == mask;

	// Restart the divider on start so the first converter clock has full length
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_reg <= '0;
		end else if (cif.start) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 7'h01;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= tick_now && !cif.start;
		end
	end

	// ========================================
	// Conversion length counter
	adsq_state_e state_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic done_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (cif.start) begin
						state_reg <= ST_CONV;
						cnt_reg <= '0;
					end
				end
				ST_CONV: begin
					if (cif.abort) begin
						state_reg <= ST_IDLE;
					end else if (tick_reg) begin
						if (cnt_reg == CNT_W'(CONV_CLKS - 1)) begin
							state_reg <= ST_IDLE;
							done_reg <= 1'b1;
						end else begin
							cnt_reg <= cnt_reg + 8'h01;
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	assign cif.tick = tick_reg && (state_reg == ST_CONV);
	assign cif.done = done_reg;
	assign cif.active = state_reg == ST_CONV;
endmodule
`default_nettype wire

// >>> rtl/adsq_top.sv
// Functional notes
// - Each conversion yields a 12-bit unsigned value of the selected input.
// - Result sits in two read-only bytes; two control bytes configure.
// - Justify 0: high=D11..4, low top nibble=D3..0; 1: high nibble D11..8, low D7..0.
// - Result bits carrying no data read as zero.
// - Result bytes hold their contents while the converter is disabled.
// - Conversion starts when start bit is written high then low.
// - Busy flag goes to one once a conversion is started.
// - Busy flag clears when the conversion completes with a new result.
// - Busy flag is read-only; writes to it do nothing.
// - Enable low powers the converter down; enable high makes it work.
// - Channel codes 0..7 route a pin; top bit set selects no pin.
// - Source 000,101-111 external; 001 bandgap; 010-100 ground.
// - Reference code 01 takes supply; 00 and 1x take external pin.
// - Converter clock is system clock divided by 1 to 128 by code.
// - Analog pins lose their digital function and pull-up.
// - Completion sets an interrupt flag; interrupt raised only if enabled.
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "adsq_consts.svh"
module adsq_top import adsq_pkg::*; #(
	parameter int CONV_CLKS = `ADSQ_CONV_CLKS,
	parameter int NUM_CH = `ADSQ_NUM_CH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [`ADSQ_ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Interrupt
	output logic irq,
	// Pin-shared function selection
	input wire logic [NUM_CH-1:0] analog_pin_sel,
	output logic [NUM_CH-1:0] pin_digital_off,
	output logic [NUM_CH-1:0] pin_pullup_off,
	// Analog front end control
	output logic afe_power_on,
	output logic [NUM_CH-1:0] analog_input_pins_sel,
	output logic bandgap_reference_sel,
	output logic ground_sel,
	output logic ref_supply_sel,
	output logic afe_conv_clk,
	output logic afe_sample,
	// Analog front end result
	input wire logic [11:0] afe_data
);
	if (NUM_CH != `ADSQ_NUM_CH) begin : g_bad_ch
		$error("NUM_CH must equal the 3-bit channel code range");
	end

	// ========================================
	// Decoding helpers
	function automatic logic [`ADSQ_NUM_CH-1:0] chan_onehot(input logic [3:0] code);
		logic [`ADSQ_NUM_CH-1:0] v;
		v = '0;
		if (!code[3]) begin
			v[code[2:0]] = 1'b1;
		end
		return v;
	endfunction

	function automatic adsq_src_e src_decode(input logic [2:0] code);
		adsq_src_e s;
		if (code == `ADSQ_SRC_BANDGAP) begin
			s = SRC_BANDGAP;
		end else if (code >= `ADSQ_SRC_GND_LO && code <= `ADSQ_SRC_GND_HI) begin
			s = SRC_GROUND;
		end else begin
			s = SRC_EXT;
		end
		return s;
	endfunction

	function automatic logic sel_hit(input logic [`ADSQ_ADDR_W-1:0] a,
			input logic [`ADSQ_ADDR_W-1:0] idx);
		return a == idx;
	endfunction

	// ========================================
	// Control registers
	adsq_byte_t converter_control_a_reg;
	adsq_byte_t converter_control_b_reg;
	logic conversion_busy_flag_reg;
	logic wr_a;
	logic wr_b;
	logic start_seq;
	logic start_ok;
	logic converter_enable_bit;
	logic result_justify_select;
	logic [3:0] external_channel_select;
	logic [2:0] input_source_select;
	logic [1:0] reference_source_select;
	logic [2:0] conversion_clock_divider;

	assign wr_a = wr && sel_hit(addr, `ADSQ_IDX_CTRL_A);
	assign wr_b = wr && sel_hit(addr, `ADSQ_IDX_CTRL_B);

	assign converter_enable_bit = converter_control_a_reg[`ADSQ_A_EN];
	assign result_justify_select = converter_control_a_reg[`ADSQ_A_JUST];
	assign external_channel_select =
		converter_control_a_reg[`ADSQ_A_CH_HI:`ADSQ_A_CH_LO];
	assign input_source_select =
		converter_control_b_reg[`ADSQ_B_SRC_HI:`ADSQ_B_SRC_LO];
	assign reference_source_select =
		converter_control_b_reg[`ADSQ_B_REF_HI:`ADSQ_B_REF_LO];
	assign conversion_clock_divider =
		converter_control_b_reg[`ADSQ_B_DIV_HI:`ADSQ_B_DIV_LO];

	// A single write of one never starts anything; only the falling write does
	assign start_seq = wr_a && converter_control_a_reg[`ADSQ_A_START]
		&& !wdata[`ADSQ_A_START];
	assign start_ok = start_seq && converter_enable_bit
		&& !conversion_busy_flag_reg;

	// Busy bit position is masked out of the stored write value
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			converter_control_a_reg <= `ADSQ_CTRL_RST;
		end else if (wr_a) begin
			converter_control_a_reg <= wdata & `ADSQ_A_WMASK;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			converter_control_b_reg <= `ADSQ_CTRL_RST;
		end else if (wr_b) begin
			converter_control_b_reg <= wdata;
		end
	end

	// ========================================
	// Conversion timing
	adsq_conv_if cif();
	logic abort;

	// Dropping enable mid-conversion stops it; no result is written
	assign abort = !converter_enable_bit;
	assign cif.start = start_ok;
	assign cif.abort = abort;
	assign cif.div_sel = conversion_clock_divider;

	adsq_conv_timer #(
		.CONV_CLKS(CONV_CLKS)
	) u_timer (
		.clk(clk),
		.rst(rst),
		.cif(cif)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conversion_busy_flag_reg <= 1'b0;
		end else if (start_ok) begin
			conversion_busy_flag_reg <= 1'b1;
		end else if (cif.done || abort) begin
			conversion_busy_flag_reg <= 1'b0;
		end
	end

	// ========================================
	// Result capture
	adsq_data_t data_meta_reg;
	adsq_data_t data_sync_reg;
	adsq_byte_t result_low_byte_reg;
	adsq_byte_t result_high_byte_reg;
	adsq_byte_t result_low_next;
	adsq_byte_t result_high_next;

	// Converter output comes from the analog macro's own timing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_meta_reg <= '0;
			data_sync_reg <= '0;
		end else begin
			data_meta_reg <= afe_data;
			data_sync_reg <= data_meta_reg;
		end
	end

	always_comb begin
		if (result_justify_select) begin
			result_high_next = {4'h0, data_sync_reg[11:8]};
			result_low_next = data_sync_reg[7:0];
		end else begin
			result_high_next = data_sync_reg[11:4];
			result_low_next = {data_sync_reg[3:0], 4'h0};
		end
	end

	// Formatted once at capture, so later justify changes do not disturb held data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			result_low_byte_reg <= `ADSQ_RES_RST;
			result_high_byte_reg <= `ADSQ_RES_RST;
		end else if (cif.done && converter_enable_bit) begin
			result_low_byte_reg <= result_low_next;
			result_high_byte_reg <= result_high_next;
		end
	end

	// ========================================
	// Interrupt status and mask
	adsq_byte_t irq_stat_reg;
	adsq_byte_t irq_mask_reg;
	logic wr_stat;
	logic wr_mask;

	assign wr_stat = wr && sel_hit(addr, `ADSQ_IDX_IRQ_STAT);
	assign wr_mask = wr && sel_hit(addr, `ADSQ_IDX_IRQ_MASK);

	// A completion in the cycle of a clear still lands
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_stat_reg <= `ADSQ_IRQ_RST;
		end else if (cif.done) begin
			irq_stat_reg[`ADSQ_IRQ_DONE] <= 1'b1;
		end else if (wr_stat) begin
			irq_stat_reg <= irq_stat_reg & ~(wdata & `ADSQ_IRQ_WMASK);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_mask_reg <= `ADSQ_IRQ_RST;
		end else if (wr_mask) begin
			irq_mask_reg <= wdata & `ADSQ_IRQ_WMASK;
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	// ========================================
	// Register read port
	adsq_byte_t rd_value;
	adsq_byte_t rdata_reg;

	always_comb begin
		case (addr)
			`ADSQ_IDX_CTRL_A: begin
				rd_value = converter_control_a_reg;
				rd_value[`ADSQ_A_BUSY] = conversion_busy_flag_reg;
			end
			`ADSQ_IDX_CTRL_B: rd_value = converter_control_b_reg;
			`ADSQ_IDX_RES_LOW: rd_value = result_low_byte_reg;
			`ADSQ_IDX_RES_HIGH: rd_value = result_high_byte_reg;
			`ADSQ_IDX_IRQ_STAT: rd_value = irq_stat_reg;
			`ADSQ_IDX_IRQ_MASK: rd_value = irq_mask_reg;
			default: rd_value = 8'h00;
		endcase
	end

	// Data stand only in the cycle after the strobe, zero otherwise
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= 8'h00;
		end else if (rd) begin
			rdata_reg <= rd_value;
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	assign rdata = rdata_reg;

	// ========================================
	// Analog routing
	adsq_src_e src;
	logic [NUM_CH-1:0] chan_sel_next;
	logic [NUM_CH-1:0] chan_sel_reg;
	logic bandgap_reg;
	logic ground_reg;
	logic ref_supply_reg;
	logic power_reg;
	logic conv_clk_reg;
	logic sample_reg;

	assign src = src_decode(input_source_select);
	// Pins route only for an external source; bandgap and ground force every pin select off
	assign chan_sel_next = (src == SRC_EXT) ?
		chan_onehot(external_channel_select) : '0;

	// Everything is switched off while disabled to keep the macro unpowered
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			power_reg <= 1'b0;
			chan_sel_reg <= '0;
			bandgap_reg <= 1'b0;
			ground_reg <= 1'b0;
			ref_supply_reg <= 1'b0;
		end else begin
			power_reg <= converter_enable_bit;
			chan_sel_reg <= converter_enable_bit ? chan_sel_next : '0;
			bandgap_reg <= converter_enable_bit && (src == SRC_BANDGAP);
			ground_reg <= converter_enable_bit && (src == SRC_GROUND);
			ref_supply_reg <= converter_enable_bit
				&& (reference_source_select == `ADSQ_REF_SUPPLY);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conv_clk_reg <= 1'b0;
			sample_reg <= 1'b0;
		end else begin
			conv_clk_reg <= cif.tick;
			sample_reg <= cif.active;
		end
	end

	assign afe_power_on = power_reg;
	assign analog_input_pins_sel = chan_sel_reg;
	assign bandgap_reference_sel = bandgap_reg;
	assign ground_sel = ground_reg;
	assign ref_supply_sel = ref_supply_reg;
	assign afe_conv_clk = conv_clk_reg;
	assign afe_sample = sample_reg;

	// ========================================
	// Pin function override
	logic [NUM_CH-1:0] dig_off_reg;
	logic [NUM_CH-1:0] pu_off_reg;

	for (genvar i = 0; i < NUM_CH; i++) begin : g_pin
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				dig_off_reg[i] <= 1'b0;
				pu_off_reg[i] <= 1'b0;
			end else begin
				dig_off_reg[i] <= analog_pin_sel[i];
				pu_off_reg[i] <= analog_pin_sel[i];
			end
		end
	end

	assign pin_digital_off = dig_off_reg;
	assign pin_pullup_off = pu_off_reg;
endmodule
`default_nettype wire

// >>> tb/adsq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "adsq_consts.svh"
module adsq_chk #(
	parameter int CONV_CLKS = 16,
	parameter int NUM_CH = 8
) (
	// Clock, reset, register port
	input wire logic clk,
	input wire logic rst,
	input wire logic [`ADSQ_ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic irq,
	// Pins and front end
	input wire logic [NUM_CH-1:0] analog_pin_sel,
	input wire logic [NUM_CH-1:0] pin_digital_off,
	input wire logic [NUM_CH-1:0] pin_pullup_off,
	input wire logic afe_power_on,
	input wire logic [NUM_CH-1:0] analog_input_pins_sel,
	input wire logic bandgap_reference_sel,
	input wire logic ground_sel,
	input wire logic ref_supply_sel,
	input wire logic afe_conv_clk,
	input wire logic afe_sample
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic wa;
	logic [2:0] div_reg;
	assign wa = wr && addr == `ADSQ_IDX_CTRL_A;
	// ==========
	// Divider code shadowed from bus writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_reg <= 3'h0;
		end else if (wr && addr == `ADSQ_IDX_CTRL_B) begin
			div_reg <= wdata[2:0];
		end
	end
	// ==========
	// Properties
	property p_rd_idle;
		!rd |=> rdata == 8'h00;
	endproperty
	property p_pin_off;
		1'b1 |=> pin_digital_off == $past(analog_pin_sel);
	endproperty
	property p_pullup;
		pin_pullup_off == pin_digital_off;
	endproperty
	property p_pow;
		wa ##1 !wa |=> afe_power_on == $past(wdata[5], 2);
	endproperty
	property p_off;
		!afe_power_on |-> analog_input_pins_sel == '0 && !bandgap_reference_sel
			&& !ground_sel && !ref_supply_sel;
	endproperty
	property p_ch_none;
		wa && wdata[3] ##1 !wa [*2] |-> analog_input_pins_sel == '0;
	endproperty
	property p_excl;
		$onehot0({analog_input_pins_sel, bandgap_reference_sel, ground_sel});
	endproperty
	property p_start_en;
		$rose(afe_sample) |-> $past(afe_power_on);
	endproperty
	property p_off_idle;
		!afe_power_on [*2] |-> !afe_sample && !afe_conv_clk;
	endproperty
	property p_irq;
		$rose(irq) |-> $past(afe_sample) || $past(wr && addr == `ADSQ_IDX_IRQ_MASK);
	endproperty
	property p_gap;
		afe_conv_clk && div_reg != 3'h0 |=> !afe_conv_clk;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	a_pin_off: assert property (p_pin_off) else $error("digital off wrong");
	a_pullup: assert property (p_pullup) else $error("pull-up off wrong");
	a_pow: assert property (p_pow) else $error("power not enable");
	a_off: assert property (p_off) else $error("routing while off");
	a_ch_none: assert property (p_ch_none) else $error("pin routed");
	a_excl: assert property (p_excl) else $error("two inputs routed");
	a_start_en: assert property (p_start_en) else $error("start while off");
	a_off_idle: assert property (p_off_idle) else $error("sampling while off");
	a_irq: assert property (p_irq) else $error("irq without cause");
	a_gap: assert property (p_gap) else $error("clock not divided");
	c_conv: cover property ($fell(afe_sample));
	c_irq: cover property ($rose(irq));
	c_bg: cover property (bandgap_reference_sel);
	c_gnd: cover property (ground_sel);
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "adsq_consts.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("mismatch %s expected %h seen %h", n, e, g); end end
module tb;
	localparam int CONV_CLKS = 2;
	logic clk, rst, wr, rd, irq, afe_power_on, bandgap_reference_sel, ground_sel;
	logic ref_supply_sel, afe_conv_clk, afe_sample;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, analog_pin_sel, pin_digital_off, pin_pullup_off;
	logic [7:0] analog_input_pins_sel;
	logic [11:0] afe_data;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	adsq_top #(.CONV_CLKS(CONV_CLKS)) dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .analog_pin_sel(analog_pin_sel),
		.pin_digital_off(pin_digital_off), .pin_pullup_off(pin_pullup_off),
		.afe_power_on(afe_power_on), .analog_input_pins_sel(analog_input_pins_sel),
		.bandgap_reference_sel(bandgap_reference_sel), .ground_sel(ground_sel),
		.ref_supply_sel(ref_supply_sel), .afe_conv_clk(afe_conv_clk),
		.afe_sample(afe_sample), .afe_data(afe_data));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc >= 20000) begin
			n_fail++;
			give_verdict;
		end
	end
	// ==========
	// Bus tasks
	task automatic put(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
		@(posedge clk);
	endtask
	task automatic wreg(input logic [2:0] a, input logic [7:0] d);
		put(1'b1, 1'b0, a, d);
		put(1'b0, 1'b0, a, d);
	endtask
	// Read data stands for one cycle only, so sample it mid-cycle
	task automatic rget(input logic [2:0] a, output logic [7:0] v);
		put(1'b0, 1'b1, a, 8'h00);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
		@(posedge clk);
	endtask
	task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string n);
		logic [7:0] v;
		rget(a, v);
		`CHK(n, e, v)
	endtask
	// ==========
	// Scenarios
	task automatic t_ro;
		for (int i = 0; i < 8; i++) rchk(3'(i), 8'h00, "reset value");
		wreg(`ADSQ_IDX_CTRL_A, 8'h40);
		rchk(`ADSQ_IDX_CTRL_A, 8'h00, "busy written");
		wreg(`ADSQ_IDX_RES_LOW, 8'hff);
		rchk(`ADSQ_IDX_RES_LOW, 8'h00, "result written");
		wreg(`ADSQ_IDX_CTRL_A, 8'h80);
		wreg(`ADSQ_IDX_CTRL_A, 8'h00);
		rchk(`ADSQ_IDX_CTRL_A, 8'h00, "start while off");
	endtask
	task automatic t_route;
		logic ext;
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 8; i++) begin
				ext = i == 0 || i > 4;
				analog_pin_sel <= 8'h01 << i;
				wreg(`ADSQ_IDX_CTRL_B, {3'(i), 2'(i), 3'h0});
				// Bandgap runs keep the channel code at 1xxx
				wreg(`ADSQ_IDX_CTRL_A, {4'h2, 1'(j) | 1'(i == 1), 3'(i)});
				@(negedge clk);
				`CHK("pins", (ext && !j) ? 8'h01 << i : 8'h00, analog_input_pins_sel)
				`CHK("bandgap", 1'(i == 1), bandgap_reference_sel)
				`CHK("ground", 1'(i > 1 && i < 5), ground_sel)
				`CHK("supply", 1'(i % 4 == 1), ref_supply_sel)
				`CHK("pin off", 8'h01 << i, pin_digital_off)
				`CHK("power", 1'b1, afe_power_on)
				@(posedge clk);
			end
		end
	endtask
	task automatic conv(input logic j, input logic [11:0] d, input logic [2:0] dv, input logic m);
		logic [7:0] v;
		int t;
		afe_data <= d;
		wreg(`ADSQ_IDX_IRQ_MASK, {7'h0, m});
		wreg(`ADSQ_IDX_CTRL_B, {5'h0, dv});
		wreg(`ADSQ_IDX_CTRL_A, {3'h5, j, 4'h2});
		rchk(`ADSQ_IDX_CTRL_A, {3'h5, j, 4'h2}, "armed");
		wreg(`ADSQ_IDX_CTRL_A, {3'h1, j, 4'h2});
		rchk(`ADSQ_IDX_CTRL_A, {3'h3, j, 4'h2}, "busy");
		// Busy falls CONV_CLKS divided clocks plus two cycles after the start edge;
		// reads land one cycle before and one cycle after that edge
		t = (CONV_CLKS << dv) + 2;
		repeat (t - 5) @(posedge clk);
		rget(`ADSQ_IDX_CTRL_A, v);
		`CHK("busy before end", 1'b1, v[6])
		rget(`ADSQ_IDX_CTRL_A, v);
		`CHK("busy clears", 1'b0, v[6])
		rchk(`ADSQ_IDX_RES_HIGH, j ? {4'h0, d[11:8]} : d[11:4], "high");
		rchk(`ADSQ_IDX_RES_LOW, j ? d[7:0] : {d[3:0], 4'h0}, "low");
		rchk(`ADSQ_IDX_IRQ_STAT, 8'h01, "done flag");
		`CHK("irq", m, irq)
		wreg(`ADSQ_IDX_IRQ_STAT, 8'h01);
		`CHK("irq cleared", 1'b0, irq)
	endtask
	task automatic t_abort;
		afe_data <= 12'h123;
		wreg(`ADSQ_IDX_CTRL_B, 8'h07);
		wreg(`ADSQ_IDX_CTRL_A, 8'hb2);
		wreg(`ADSQ_IDX_CTRL_A, 8'h32);
		wreg(`ADSQ_IDX_CTRL_A, 8'h12);
		rchk(`ADSQ_IDX_CTRL_A, 8'h12, "aborted");
		rchk(`ADSQ_IDX_RES_HIGH, 8'h0f, "held high");
		rchk(`ADSQ_IDX_RES_LOW, 8'hff, "held low");
		rchk(`ADSQ_IDX_IRQ_STAT, 8'h00, "no flag");
		`CHK("sampling", 1'b0, afe_sample)
	endtask
	task automatic give_verdict;
		if (n_fail == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		analog_pin_sel = 8'h00;
		afe_data = 12'h000;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_ro;
		t_route;
		conv(1'b0, 12'hfff, 3'h1, 1'b0);
		conv(1'b1, 12'h5a3, 3'h7, 1'b1);
		conv(1'b0, 12'h0c1, 3'h3, 1'b1);
		conv(1'b1, 12'hfff, 3'h2, 1'b0);
		t_abort;
		give_verdict;
	end
endmodule
bind adsq_top adsq_chk #(.CONV_CLKS(CONV_CLKS), .NUM_CH(NUM_CH)) u_chk (.clk(clk), .rst(rst),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
	.analog_pin_sel(analog_pin_sel), .pin_digital_off(pin_digital_off),
	.pin_pullup_off(pin_pullup_off), .afe_power_on(afe_power_on),
	.analog_input_pins_sel(analog_input_pins_sel), .bandgap_reference_sel(bandgap_reference_sel),
	.ground_sel(ground_sel), .ref_supply_sel(ref_supply_sel), .afe_conv_clk(afe_conv_clk),
	.afe_sample(afe_sample));
`default_nettype wire
